// File: design/adc_ext_clock_serial_host_port.sv
`timescale 1ns/1ns
module adc_ext_clock_serial_host_port #(
    parameter int WORD_BITS = serial_host_pkg::WORD_BITS
) (
    input  wire logic                 ref_clk,        // System clock.
    input  wire logic                 reset,          // Async reset, high.
    input  wire logic                 clk_en,         // State freeze when low.
    input  wire logic [1:0]           wiring,         // Strobe wiring option.
    input  wire logic                 lsb_first,      // Mirror each byte.
    input  wire logic                 cmd_valid,      // Command request.
    output logic                      cmd_ready,      // Command accepted.
    input  wire logic                 cmd_write,      // 1 write, 0 read.
    input  wire logic                 cmd_sel,        // reg_select level.
    input  wire logic [WORD_BITS-1:0] cmd_wdata,      // Word to write.
    output logic                      rd_valid,       // Read word valid.
    input  wire logic                 rd_ready,       // Reader accepts.
    output logic [WORD_BITS-1:0]      rd_data,        // Read word.
    output logic                      sclk,           // Serial clock out.
    output logic                      read_frame_n,   // Read strobe.
    output logic                      write_frame_n,  // Write strobe.
    output logic                      reg_select,     // Register select.
    output logic                      serial_io_line_o,        // Serial line out.
    output logic                      serial_io_line_oe_n,     // Low while driving.
    input  wire logic                 serial_io_line_i,        // Serial line in.
    input  wire logic                 result_ready_n  // Data ready, low.
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_WAIT = 2'h1,
        S_LOW  = 2'h3,
        S_HIGH = 2'h2
    } phase_e;

    typedef struct packed {
        phase_e                 phase;
        logic                   write;
        logic                   sel;
        logic [WORD_BITS-1:0]   shreg;
        logic [4:0]             bitn;
        logic [7:0]             half;
        logic                   sclk;
        logic                   rframe_n;
        logic                   wframe_n;
        logic                   oe_n;
        logic                   push;
        logic [1:0]             rdy_sync;
    } host_s;

    host_s st_ff;
    host_s nxt_st;

    // A frame ends one low half after the last falling clock edge.
    localparam logic [4:0] FRAME_END = 5'(WORD_BITS);
    localparam logic [7:0] HALF_END = 8'(serial_host_pkg::HALF_CYCLES - 1);

    word_buffer_if #(.W(WORD_BITS)) bif ();

    word_buffer #(.W(WORD_BITS)) u_buf (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .bif     (bif)
    );

    // Mirrors each byte of a word when the user side is LSB-first.
    function automatic logic [WORD_BITS-1:0] mirror_bytes(
        input logic [WORD_BITS-1:0] w
    );
        logic [WORD_BITS-1:0] r;
        r = w;
        for (int b = 0; b < WORD_BITS / serial_host_pkg::BYTE_BITS; b++) begin
            for (int i = 0; i < serial_host_pkg::BYTE_BITS; i++) begin
                r[b*serial_host_pkg::BYTE_BITS+i] =
                    w[b*serial_host_pkg::BYTE_BITS
                      + serial_host_pkg::BYTE_BITS-1-i];
            end
        end
        return r;
    endfunction

    logic rdy_low;
    logic last_half;
    logic tied;
    logic inv_rd;

    assign rdy_low   = ~st_ff.rdy_sync[1];
    assign last_half = (st_ff.half == HALF_END);
    assign tied      = (wiring == serial_host_pkg::WIRE_TIED_SEL);
    assign inv_rd    = (wiring == serial_host_pkg::WIRE_INV_READ);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.push = 1'b0;
        nxt_st.rdy_sync = {st_ff.rdy_sync[0], result_ready_n};
        unique case (st_ff.phase)
            S_IDLE: begin
                nxt_st.sclk = 1'b0;
                if (cmd_valid) begin
                    nxt_st.write = cmd_write;
                    // Tied wiring forces control writes and output reads.
                    nxt_st.sel = tied ? ~cmd_write : cmd_sel;
                    nxt_st.shreg = lsb_first ? mirror_bytes(cmd_wdata)
                                             : cmd_wdata;
                    nxt_st.bitn = '0;
                    nxt_st.half = '0;
                    nxt_st.phase = S_WAIT;
                end
            end
            S_WAIT: begin
                // Only output-register reads wait for a ready result.
                if (st_ff.write || !st_ff.sel || rdy_low) begin
                    if (st_ff.write) begin
                        nxt_st.wframe_n = 1'b0;
                        nxt_st.oe_n = 1'b0;
                        // Every wiring keeps read strobe high here.
                        nxt_st.rframe_n = 1'b1;
                    end else begin
                        nxt_st.rframe_n = 1'b0;
                        nxt_st.wframe_n = inv_rd ? 1'b0 : 1'b1;
                        if (inv_rd) begin
                            nxt_st.wframe_n = 1'b1;
                        end
                    end
                    nxt_st.phase = S_LOW;
                end
            end
            S_LOW: begin
                if (bif.in_ready || st_ff.write) begin
                    nxt_st.half = st_ff.half + 8'h01;
                    if (last_half) begin
                        nxt_st.half = '0;
                        // Strobes rise inside a low half of the clock, so
                        // the device still sees the final falling edge.
                        if (st_ff.bitn == FRAME_END) begin
                            nxt_st.rframe_n = 1'b1;
                            nxt_st.wframe_n = 1'b1;
                            nxt_st.oe_n = 1'b1;
                            nxt_st.sel = 1'b1;
                            nxt_st.push = ~st_ff.write;
                            nxt_st.phase = S_IDLE;
                        end else begin
                            nxt_st.sclk = 1'b1;
                            nxt_st.phase = S_HIGH;
                        end
                    end
                end
            end
            S_HIGH: begin
                nxt_st.half = st_ff.half + 8'h01;
                if (last_half) begin
                    nxt_st.half = '0;
                    nxt_st.sclk = 1'b0;
                    // MSB first both ways; one frame spans all 24 bits.
                    nxt_st.shreg = {st_ff.shreg[WORD_BITS-2:0],
                                    st_ff.write ? 1'b0 : serial_io_line_i};
                    nxt_st.bitn = st_ff.bitn + 5'h01;
                    nxt_st.phase = S_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.phase <= S_IDLE;
            st_ff.rframe_n <= 1'b1;
            st_ff.wframe_n <= 1'b1;
            st_ff.sel <= 1'b1;
            st_ff.oe_n <= 1'b1;
            st_ff.rdy_sync <= 2'h3;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready     = (st_ff.phase == S_IDLE) && !st_ff.push;
    assign sclk          = st_ff.sclk;
    assign read_frame_n  = st_ff.rframe_n;
    assign write_frame_n = st_ff.wframe_n;
    assign reg_select    = st_ff.sel;
    assign serial_io_line_o       = st_ff.shreg[WORD_BITS-1];
    assign serial_io_line_oe_n    = st_ff.oe_n;

    // A read pauses in a low half while the buffer is full; the push lasts one cycle.
    assign bif.in_valid  = st_ff.push;
    assign bif.in_data   = lsb_first ? mirror_bytes(st_ff.shreg)
                                     : st_ff.shreg;
    assign rd_valid      = bif.out_valid;
    assign rd_data       = bif.out_data;
    assign bif.out_ready = rd_ready;
endmodule // adc_ext_clock_serial_host_port

// File: design/serial_host_pkg.sv
package serial_host_pkg;
    localparam int WORD_BITS     = 24;
    localparam int BYTE_BITS     = 8;
    localparam int BYTES_PER_WORD = WORD_BITS / BYTE_BITS;
    localparam int CLK_MHZ       = 100;
    localparam int SCLK_HALF_NS  = 40;
    localparam int HALF_CYCLES   = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] WIRE_FULL     = 2'h0;
    localparam logic [1:0] WIRE_TIED_SEL = 2'h1;
    localparam logic [1:0] WIRE_INV_READ = 2'h2;
endpackage

// File: design/word_buffer_if.sv
`timescale 1ns/1ns
interface word_buffer_if #(parameter int W = 24);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fill  (output in_valid, output in_data, input in_ready);
    modport drain (input out_valid, input out_data, output out_ready);
    modport buf_side (input in_valid, input in_data, output in_ready,
                      output out_valid, output out_data, input out_ready);
endinterface

// File: design/word_buffer.sv
`timescale 1ns/1ns
module word_buffer #(
    parameter int W = 24
) (
    input  wire logic ref_clk,       // System clock.
    input  wire logic reset,         // Async reset, active high.
    input  wire logic clk_en,        // Freezes state while low.
    word_buffer_if.buf_side bif      // Fill and drain sides.
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wr;
        logic              rd;
        logic [1:0]        cnt;
    } buf_s;
    buf_s st_ff;
    buf_s nxt_st;
    logic push;
    logic pop;

    assign bif.in_ready  = (st_ff.cnt != 2'h2);
    assign bif.out_valid = (st_ff.cnt != 2'h0);
    assign bif.out_data  = st_ff.mem[st_ff.rd];
    assign push = bif.in_valid && bif.in_ready;
    assign pop  = bif.out_valid && bif.out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = bif.in_data;
            nxt_st.wr = ~st_ff.wr;
        end
        if (pop) begin
            nxt_st.rd = ~st_ff.rd;
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
endmodule // word_buffer

// File: tb/adc_host_port_sva.sv
`timescale 1ns/1ns
module adc_host_port_sva #(
    parameter int WORD_BITS = 24
) (
    input wire logic                 ref_clk,        // Clock.
    input wire logic                 reset,          // Reset.
    input wire logic [1:0]           wiring,         // Wiring.
    input wire logic                 sclk,           // Shift clock.
    input wire logic                 read_frame_n,   // Read strobe.
    input wire logic                 write_frame_n,  // Write strobe.
    input wire logic                 reg_select,     // Select.
    input wire logic                 serial_io_line_oe_n,     // Drive, low.
    input wire logic                 result_ready_n, // Ready, low.
    input wire logic                 rd_valid,       // Word valid.
    input wire logic                 rd_ready,       // Word taken.
    input wire logic [WORD_BITS-1:0] rd_data         // Word.
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    logic       sclk_ff;
    logic       wr_act;
    logic [5:0] bits_ff;
    assign wr_act = !write_frame_n && wiring != 2'h2;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sclk_ff <= 1'b0;
            bits_ff <= 6'h00;
        end else begin
            sclk_ff <= sclk;
            if (read_frame_n && !wr_act) bits_ff <= 6'h00;
            else if (sclk && !sclk_ff) bits_ff <= bits_ff + 6'h01;
        end
    end
    sequence s_high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_ready_idle;
        result_ready_n [*4];
    endsequence
    a_strobe_excl: assert property (read_frame_n || write_frame_n)
        else $error("both strobes low");
    a_sel_steady: assert property (!read_frame_n && !$past(read_frame_n)
        |-> $stable(reg_select)) else $error("select moved");
    a_sclk_idle: assert property (read_frame_n && write_frame_n |-> !sclk)
        else $error("clock high while idle");
    a_sclk_high: assert property ($rose(sclk) |-> s_high_phase)
        else $error("high phase wrong");
    a_read_oe: assert property (!read_frame_n |-> serial_io_line_oe_n)
        else $error("line driven in read");
    a_tied_write: assert property (wiring == 2'h1 && wr_act |-> !reg_select)
        else $error("tied write select");
    a_tied_read: assert property (wiring == 2'h1 && !read_frame_n |-> reg_select)
        else $error("tied read select");
    a_ready_gate: assert property (s_ready_idle ##0 $fell(read_frame_n)
        |-> !reg_select) else $error("read without ready");
    a_frame_bits: assert property ($rose(read_frame_n)
        |-> bits_ff == WORD_BITS) else $error("bit count");
    a_result_hold: assert property (rd_valid && !rd_ready
        |=> rd_valid && $stable(rd_data)) else $error("result dropped");
endmodule // adc_host_port_sva
bind adc_ext_clock_serial_host_port adc_host_port_sva #(
    .WORD_BITS(WORD_BITS)) u_sva (.*);

// File: tb/adc_serial_device_model.sv
`timescale 1ns/1ns
module adc_serial_device_model (
    input  wire logic        sclk,           // Shift clock.
    input  wire logic        read_frame_n,   // Read strobe.
    input  wire logic        write_frame_n,  // Write strobe.
    input  wire logic        reg_select,     // Select.
    input  wire logic        serial_io_line_in,       // Line level.
    output logic             serial_io_line_out,      // Device drive.
    output logic             result_ready_n, // Ready, low.
    input  wire logic        load,           // New result.
    input  wire logic [23:0] result,         // Result word.
    output logic [23:0]      ctrl_q          // Control word.
);
    logic [23:0] cal_q, out_q, sh, wsh;
    logic        from_out;
    int          rbits, wbits;
    initial begin
        {ctrl_q, out_q, cal_q} = {48'h0, 24'h5A5A5A};
        {result_ready_n, serial_io_line_out, wbits} = {2'h2, 32'h0};
    end
    always @(posedge load) begin
        out_q = result;
        result_ready_n = 1'b0;
    end
    always @(negedge read_frame_n) begin
        from_out = reg_select && !result_ready_n;
        sh = !reg_select ? ctrl_q : (from_out ? out_q : cal_q);
        rbits = 0;
        serial_io_line_out = sh[23];
    end
    // A released line shows the inverse, so a stale bit never passes.
    always @(posedge read_frame_n) serial_io_line_out = ~serial_io_line_out;
    always @(negedge sclk) if (!read_frame_n) begin
        sh = sh << 1;
        rbits++;
        serial_io_line_out = sh[23];
        if (rbits == 24 && from_out) result_ready_n = 1'b1;
    end
    always @(negedge write_frame_n) wbits = 0;
    always @(posedge sclk) if (!write_frame_n) begin
        wsh = {wsh[22:0], serial_io_line_in};
        wbits++;
        if (wbits == 24) begin
            if (reg_select) cal_q = wsh; else ctrl_q = wsh;
            wbits = 0;
        end
    end
endmodule // adc_serial_device_model

// File: tb/test_adc_ext_clock_serial_host_port.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module test_adc_ext_clock_serial_host_port;
    logic        ref_clk, reset, clk_en, lsb_first, cmd_valid, cmd_ready;
    logic        cmd_write, cmd_sel, rd_valid, rd_ready, sclk, serial_io_line_o;
    logic        read_frame_n, write_frame_n, reg_select, serial_io_line_oe_n;
    logic        serial_io_line_i, dev_o, result_ready_n, load;
    logic [1:0]  wiring;
    logic [23:0] cmd_wdata, rd_data, result, ctrl_q, d;
    int          fails, checked;
    assign serial_io_line_i = serial_io_line_oe_n ? dev_o : serial_io_line_o;
    adc_ext_clock_serial_host_port DUT (.*);
    adc_serial_device_model peer (.sclk, .read_frame_n, .write_frame_n,
        .reg_select, .serial_io_line_in(serial_io_line_i), .serial_io_line_out(dev_o),
        .result_ready_n, .load, .result, .ctrl_q);
    task automatic send(input logic wr, sel, input logic [23:0] w);
        int n = 0;
        {cmd_valid, cmd_write, cmd_sel, cmd_wdata} <= {1'b1, wr, sel, w};
        do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 9999);
        cmd_valid <= 1'b0;
        do @(posedge ref_clk); while (wr && cmd_ready !== 1'b1 && ++n < 9999);
    endtask
    task automatic get;
        int n = 0;
        rd_ready <= 1'b1;
        do @(posedge ref_clk); while (rd_valid !== 1'b1 && ++n < 9999);
        d = rd_data;
        rd_ready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic ld(input logic [23:0] r);
        {result, load} <= {r, 1'b1};
        @(posedge ref_clk);
        load <= 1'b0;
    endtask
    task automatic t_ctrl;
        send(1, 0, 24'hA5C3F0);
        `CHK(ctrl_q, 24'hA5C3F0)
        send(0, 0, 24'h000000);
        get;
        `CHK(d, 24'hA5C3F0)
        $display("t_ctrl done");
    endtask
    task automatic t_output;
        send(0, 1, 24'h000000);
        repeat (300) @(posedge ref_clk);
        `CHK(read_frame_n, 1'b1)
        ld(24'h123456);
        get;
        `CHK(d, 24'h123456)
        `CHK(result_ready_n, 1'b1)
        $display("t_output done");
    endtask
    task automatic t_stall;
        repeat (3) send(0, 0, 24'h000000);
        repeat (3) begin
            get;
            `CHK(d, 24'hA5C3F0)
        end
        $display("t_stall done");
    endtask
    task automatic t_mirror;
        lsb_first <= 1'b1;
        send(1, 0, 24'h010203);
        `CHK(ctrl_q, 24'h8040C0)
        send(0, 0, 24'h000000);
        get;
        `CHK(d, 24'h010203)
        lsb_first <= 1'b0;
        $display("t_mirror done");
    endtask
    task automatic t_wiring;
        wiring <= 2'h1;
        send(1, 1, 24'h0F0F0F);
        `CHK(ctrl_q, 24'h0F0F0F)
        ld(24'h654321);
        send(0, 0, 24'h000000);
        get;
        `CHK(d, 24'h654321)
        wiring <= 2'h2;
        send(1, 0, 24'h3C3C3C);
        `CHK(ctrl_q, 24'h3C3C3C)
        $display("t_wiring done");
    endtask
    task automatic final_report;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Eleven frames of about 2 us each; over twelve times that before giving up.
    initial begin
        #300000;
        fails++;
        final_report;
    end
    initial begin
        {reset, clk_en, lsb_first, cmd_valid, cmd_write, cmd_sel} = 6'h30;
        {rd_ready, load, wiring, cmd_wdata, result} = 52'h0;
        {fails, checked} = 64'h0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK({read_frame_n, write_frame_n, reg_select, sclk}, 4'hE)
        t_ctrl;
        t_output;
        t_stall;
        t_mirror;
        t_wiring;
        final_report;
    end
endmodule // test_adc_ext_clock_serial_host_port
